/* File: logic/plcb_pkg.sv */
// Shared constants of the powerline bit-stream channel
package plcb_pkg;
  localparam int          NUM_CHANNELS  = 2;
  localparam int          NUM_PHASES    = 3;
  localparam int          NUM_IRQ_LINES = 8;
  localparam int          BYTE_W        = 8;
  localparam logic [7:0]  CH_FIRST      = 8'h01;
  localparam logic [7:0]  CH_LAST       = 8'h02;
  localparam logic [2:0]  IRQ_SEL_RESET = 3'h0;
  localparam int          SYNC_STAGES   = 3;
endpackage : plcb_pkg

/* File: logic/plcb_lane_if.sv */
// Carrier between the channel controller and one transmit/receive lane
`timescale 1ns/1ps
interface plcb_lane_if #(parameter int W = 8);
  logic         tx_en;
  logic         rx_en;
  logic         bit_tick;
  logic         rx_bit;
  logic         tx_valid;
  logic [W-1:0] tx_data;
  logic         tx_ready;
  logic         rx_valid;
  logic [W-1:0] rx_data;
  logic         rx_ready;
  logic         line_out;
  logic         line_oe;
  modport lane (input tx_en, rx_en, bit_tick, rx_bit, tx_valid, tx_data, rx_ready,
                output tx_ready, rx_valid, rx_data, line_out, line_oe);
  modport ctrl (output tx_en, rx_en, bit_tick, rx_bit, tx_valid, tx_data, rx_ready,
                input tx_ready, rx_valid, rx_data, line_out, line_oe);
endinterface : plcb_lane_if

/* File: logic/plcb_lane.sv */
// One lane: raw byte serialiser and raw bit packer, stepped by the bit tick
`timescale 1ns/1ps
module plcb_lane #(
  parameter int W = 8
) (
  input wire logic    clock,
  input wire logic    reset,
  plcb_lane_if.lane   lane
);
  localparam int CW = $clog2(W + 1);
  localparam logic [CW-1:0] LAST_BIT = CW'(W - 1);

  logic [W-1:0]  tx_sh_reg, tx_sh_next;
  logic [CW-1:0] tx_cnt_reg, tx_cnt_next;
  logic          out_reg, out_next;
  logic          oe_reg, oe_next;
  logic [W-1:0]  rx_sh_reg, rx_sh_next;
  logic [CW-1:0] rx_cnt_reg, rx_cnt_next;
  logic [W-1:0]  rx_data_reg, rx_data_next;
  logic          rx_valid_reg, rx_valid_next;

  // A byte is taken only at a tick with the shifter empty, so back-to-back bytes leave no gap
  assign lane.tx_ready = lane.tx_en && lane.bit_tick && (tx_cnt_reg == '0);
  assign lane.line_out = out_reg;
  assign lane.line_oe  = oe_reg;
  assign lane.rx_data  = rx_data_reg;
  assign lane.rx_valid = rx_valid_reg;

  always_comb
  begin
    tx_sh_next    = tx_sh_reg;
    tx_cnt_next   = tx_cnt_reg;
    out_next      = out_reg;
    oe_next       = oe_reg;
    rx_sh_next    = rx_sh_reg;
    rx_cnt_next   = rx_cnt_reg;
    rx_data_next  = rx_data_reg;
    rx_valid_next = rx_valid_reg;
    if (!lane.tx_en)
    begin
      tx_cnt_next = '0;
      out_next    = 1'b0;
      oe_next     = 1'b0;
    end
    else if (lane.bit_tick)
    begin
      if (tx_cnt_reg != '0)
      begin
        out_next    = tx_sh_reg[W-1];
        tx_sh_next  = {tx_sh_reg[W-2:0], 1'b0};
        tx_cnt_next = tx_cnt_reg - 1'b1;
        oe_next     = 1'b1;
      end
      else if (lane.tx_valid)
      begin
        // Bytes go out untouched; start pattern and pairs are built upstream
        out_next    = lane.tx_data[W-1];
        tx_sh_next  = {lane.tx_data[W-2:0], 1'b0};
        tx_cnt_next = LAST_BIT;
        oe_next     = 1'b1;
      end
      else
      begin
        // Empty queue: release the line, which then reads as idle
        out_next = 1'b0;
        oe_next  = 1'b0;
      end
    end
    if (!lane.rx_en)
    begin
      rx_cnt_next   = '0;
      rx_valid_next = 1'b0;
    end
    else
    begin
      if (lane.rx_ready)
        rx_valid_next = 1'b0;
      // Raw bits, no pair decoding; a new byte wins over the consumer's clear
      if (lane.bit_tick)
      begin
        rx_sh_next = {rx_sh_reg[W-2:0], lane.rx_bit};
        if (rx_cnt_reg == LAST_BIT)
        begin
          rx_data_next  = {rx_sh_reg[W-2:0], lane.rx_bit};
          rx_valid_next = 1'b1;
          rx_cnt_next   = '0;
        end
        else
          rx_cnt_next = rx_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      tx_sh_reg    <= '0;
      tx_cnt_reg   <= '0;
      out_reg      <= 1'b0;
      oe_reg       <= 1'b0;
      rx_sh_reg    <= '0;
      rx_cnt_reg   <= '0;
      rx_data_reg  <= '0;
      rx_valid_reg <= 1'b0;
    end
    else
    begin
      tx_sh_reg    <= tx_sh_next;
      tx_cnt_reg   <= tx_cnt_next;
      out_reg      <= out_next;
      oe_reg       <= oe_next;
      rx_sh_reg    <= rx_sh_next;
      rx_cnt_reg   <= rx_cnt_next;
      rx_data_reg  <= rx_data_next;
      rx_valid_reg <= rx_valid_next;
    end
  end

  sequence s_byte_taken;
    lane.tx_ready && lane.tx_valid;
  endsequence

  property p_tx_msb_first;
    @(posedge clock) disable iff (reset)
    s_byte_taken |=> lane.line_oe && (lane.line_out == $past(lane.tx_data[W-1]));
  endproperty
  a_tx_msb_first: assert property (p_tx_msb_first)
    else $error("first line bit is not the byte's top bit");

  property p_tx_release;
    @(posedge clock) disable iff (reset)
    lane.bit_tick && lane.tx_en && (tx_cnt_reg == '0) && !lane.tx_valid |=> !lane.line_oe;
  endproperty
  a_tx_release: assert property (p_tx_release)
    else $error("line still driven with an empty queue");

  property p_tx_hold;
    @(posedge clock) disable iff (reset)
    lane.tx_en && !lane.bit_tick && $past(lane.tx_en) |=> $stable(lane.line_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("line bit changed without a bit tick");

  property p_rx_raw;
    @(posedge clock) disable iff (reset)
    lane.bit_tick && lane.rx_en && (rx_cnt_reg == LAST_BIT)
      |=> lane.rx_valid && (lane.rx_data[0] == $past(lane.rx_bit));
  endproperty
  a_rx_raw: assert property (p_rx_raw)
    else $error("received byte not delivered raw after eight bits");
endmodule : plcb_lane

/* File: logic/plcb_channel.sv */
// Powerline bit-stream channel controller: open/close, zero-cross timing, lanes
// Functional notes
// - Each command stream starts with the four line bits 1110 and then carries bit pairs.
// - A zero data bit is sent on the line as the pair 01.
// - A one data bit is sent on the line as the pair 10.
// - The pair 11 is illegal: never sent, and a coding error when received.
// - The pair 00 ends a command stream and is what an idle line shows.
// - The transmitter sends queued bytes unaltered; the host builds all coding.
// - The receiver queues raw sampled line bits packed into bytes, undecoded.
// - Only channels 1 and 2 open; an out-of-range or already open channel changes nothing.
// - A channel may open transmit-only or receive-only.
// - A request that assigns neither a transmit nor a receive queue opens nothing.
// - In three-phase mode phases 2 and 3 get their own transmit and receive queues.
// - The zero-cross input is reserved while any channel is open, freed when all close.
// - Zero-cross comes through an external interrupt line, line 0 unless configured.
// - Bit timing comes from the timer's second compare; without it nothing opens.
`timescale 1ns/1ps
module plcb_channel #(
  parameter int NCH  = plcb_pkg::NUM_CHANNELS,
  parameter int NPH  = plcb_pkg::NUM_PHASES,
  parameter int NIRQ = plcb_pkg::NUM_IRQ_LINES,
  parameter int W    = plcb_pkg::BYTE_W
) (
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire logic                     open_req,
  input  wire logic [7:0]               open_channel,
  input  wire logic [NPH-1:0]           open_tx_mask,
  input  wire logic [NPH-1:0]           open_rx_mask,
  input  wire logic                     close_req,
  input  wire logic [7:0]               close_channel,
  input  wire logic [2:0]               zero_cross_irq_sel,
  input  wire logic [NIRQ-1:0]          irq_lines,
  input  wire logic                     rtc_present,
  input  wire logic                     second_compare_present,
  input  wire logic                     second_compare_match,
  input  wire logic [NCH*NPH-1:0]       tx_valid,
  input  wire logic [NCH*NPH-1:0][W-1:0] tx_data,
  output logic      [NCH*NPH-1:0]       tx_ready,
  output logic      [NCH*NPH-1:0]       rx_valid,
  output logic      [NCH*NPH-1:0][W-1:0] rx_data,
  input  wire logic [NCH*NPH-1:0]       rx_ready,
  input  wire logic [NCH*NPH-1:0]       rx_line_in,
  output logic      [NCH*NPH-1:0]       tx_line_out,
  output logic      [NCH*NPH-1:0]       tx_line_oe,
  output logic      [NCH-1:0]           channel_active,
  output logic                          open_accepted,
  output logic                          zero_cross_reserved
);
  localparam int NL = NCH * NPH;
  localparam int IW = (NCH > 1) ? $clog2(NCH) : 1;

  logic [NCH-1:0]          active_reg, active_next;
  logic [NCH-1:0][NPH-1:0] txm_reg, txm_next;
  logic [NCH-1:0][NPH-1:0] rxm_reg, rxm_next;
  logic                    acc_reg, acc_next;
  logic [2:0]              sel_reg, sel_next;
  logic [NIRQ-1:0]         irq_s1_reg, irq_s2_reg, irq_s3_reg;
  logic                    zc_lvl_reg, zc_lvl_next;
  logic                    armed_reg, armed_next;
  logic                    tick_reg, tick_next;
  logic [NL-1:0]           rx_s1_reg, rx_s2_reg, rx_s3_reg;
  logic [NL-1:0]           rx_lvl_reg, rx_lvl_next;
  logic                    timer_ok;
  logic                    open_in_range;
  logic                    close_in_range;
  logic [IW-1:0]           open_idx;
  logic [IW-1:0]           close_idx;
  logic                    open_go;
  logic                    zc_edge;

  assign timer_ok       = rtc_present && second_compare_present;
  assign open_in_range  = (open_channel >= plcb_pkg::CH_FIRST)
                          && (open_channel <= plcb_pkg::CH_LAST);
  assign close_in_range = (close_channel >= plcb_pkg::CH_FIRST)
                          && (close_channel <= plcb_pkg::CH_LAST);
  assign open_idx       = IW'(open_channel - plcb_pkg::CH_FIRST);
  assign close_idx      = IW'(close_channel - plcb_pkg::CH_FIRST);
  // Needs a queue in some direction, a free channel in range, and a running timer
  assign open_go = open_req && open_in_range && !active_reg[open_idx]
                   && ((open_tx_mask | open_rx_mask) != '0)
                   && timer_ok;

  always_comb
  begin
    active_next = active_reg;
    txm_next    = txm_reg;
    rxm_next    = rxm_reg;
    sel_next    = sel_reg;
    if (close_req && close_in_range)
    begin
      active_next[close_idx] = 1'b0;
      txm_next[close_idx]    = '0;
      rxm_next[close_idx]    = '0;
    end
    if (open_go)
    begin
      active_next[open_idx] = 1'b1;
      // Either mask may be zero for a one-way channel; bits 1 and 2 are the extra phases
      txm_next[open_idx] = open_tx_mask;
      rxm_next[open_idx] = open_rx_mask;
    end
    // The interrupt line can only move while no channel holds it
    if (active_reg == '0)
      sel_next = zero_cross_irq_sel;
    acc_next = open_go;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      active_reg <= '0;
      txm_reg    <= '0;
      rxm_reg    <= '0;
      acc_reg    <= 1'b0;
      sel_reg    <= plcb_pkg::IRQ_SEL_RESET;
    end
    else
    begin
      active_reg <= active_next;
      txm_reg    <= txm_next;
      rxm_reg    <= rxm_next;
      acc_reg    <= acc_next;
      sel_reg    <= sel_next;
    end
  end

  assign channel_active      = active_reg;
  assign open_accepted       = acc_reg;
  assign zero_cross_reserved = (active_reg != '0);

  // Zero-cross and receive pins are asynchronous: a level counts once stages two and three agree
  always_comb
  begin
    zc_lvl_next = zc_lvl_reg;
    if (irq_s2_reg[sel_reg] == irq_s3_reg[sel_reg])
      zc_lvl_next = irq_s3_reg[sel_reg];
    rx_lvl_next = rx_lvl_reg;
    for (int i = 0; i < NL; i++)
    begin
      if (rx_s2_reg[i] == rx_s3_reg[i])
        rx_lvl_next[i] = rx_s3_reg[i];
    end
  end

  assign zc_edge = (zc_lvl_next != zc_lvl_reg);

  // A crossing arms the bit slot; the compare match then fires it. A crossing wins over the clear
  always_comb
  begin
    armed_next = armed_reg;
    if (second_compare_match)
      armed_next = 1'b0;
    if (zc_edge && zero_cross_reserved)
      armed_next = 1'b1;
    tick_next = armed_reg && second_compare_match && timer_ok;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irq_s1_reg <= '0;
      irq_s2_reg <= '0;
      irq_s3_reg <= '0;
      zc_lvl_reg <= 1'b0;
      rx_s1_reg  <= '0;
      rx_s2_reg  <= '0;
      rx_s3_reg  <= '0;
      rx_lvl_reg <= '0;
      armed_reg  <= 1'b0;
      tick_reg   <= 1'b0;
    end
    else
    begin
      irq_s1_reg <= irq_lines;
      irq_s2_reg <= irq_s1_reg;
      irq_s3_reg <= irq_s2_reg;
      zc_lvl_reg <= zc_lvl_next;
      rx_s1_reg  <= rx_line_in;
      rx_s2_reg  <= rx_s1_reg;
      rx_s3_reg  <= rx_s2_reg;
      rx_lvl_reg <= rx_lvl_next;
      armed_reg  <= armed_next;
      tick_reg   <= tick_next;
    end
  end

  for (genvar l = 0; l < NL; l++)
  begin : g_lane
    plcb_lane_if #(.W(W)) lif ();
    assign lif.tx_en    = active_reg[l / NPH] && txm_reg[l / NPH][l % NPH];
    assign lif.rx_en    = active_reg[l / NPH] && rxm_reg[l / NPH][l % NPH];
    assign lif.bit_tick = tick_reg;
    assign lif.rx_bit   = rx_lvl_reg[l];
    assign lif.tx_valid = tx_valid[l];
    assign lif.tx_data  = tx_data[l];
    assign lif.rx_ready = rx_ready[l];
    assign tx_ready[l]    = lif.tx_ready;
    assign rx_valid[l]    = lif.rx_valid;
    assign rx_data[l]     = lif.rx_data;
    assign tx_line_out[l] = lif.line_out;
    assign tx_line_oe[l]  = lif.line_oe;
    plcb_lane #(.W(W)) u_lane (
      .clock (clock),
      .reset (reset),
      .lane  (lif.lane)
    );
  end

  property p_open_refused;
    @(posedge clock) disable iff (reset)
    open_req && !close_req && (!open_in_range || active_reg[open_idx])
      |=> $stable(active_reg) && $stable(txm_reg) && !open_accepted;
  endproperty
  a_open_refused: assert property (p_open_refused)
    else $error("bad or duplicate open changed channel state");

  property p_open_empty;
    @(posedge clock) disable iff (reset)
    open_req && ((open_tx_mask | open_rx_mask) == '0) |=> !open_accepted;
  endproperty
  a_open_empty: assert property (p_open_empty)
    else $error("open with no queues was accepted");

  property p_reserved;
    @(posedge clock) disable iff (reset)
    open_accepted |-> zero_cross_reserved ##0 (channel_active != '0);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("zero-cross not reserved after open");

  // Crossings seen while no channel holds the input must not arm a bit slot
  property p_zc_ignored;
    @(posedge clock) disable iff (reset)
    !zero_cross_reserved && !armed_reg |=> !armed_reg;
  endproperty
  a_zc_ignored: assert property (p_zc_ignored)
    else $error("crossing armed a bit slot with no channel open");

  property p_tick_cause;
    @(posedge clock) disable iff (reset)
    tick_reg |-> $past(armed_reg) && $past(second_compare_match) && $past(timer_ok);
  endproperty
  a_tick_cause: assert property (p_tick_cause)
    else $error("bit tick without armed crossing and compare match");

  property p_no_timer;
    @(posedge clock) disable iff (reset)
    open_req && !timer_ok |=> !open_accepted;
  endproperty
  a_no_timer: assert property (p_no_timer)
    else $error("channel opened without the compare timer");
endmodule : plcb_channel

/* File: tb/plcb_mains_model.sv */
// Mains-side partner: zero-cross edges, timer compare pulses, received command stream
`timescale 1ns/1ps
module plcb_mains_model (
  input  wire logic  clock,
  input  wire logic  reset,
  output logic       zero_cross,
  output logic       compare_match,
  output logic       rx_pin,
  output logic [5:0] slot
);
  // Host-built stream: start 1110, pairs 10 01 10, then 00 idle
  localparam logic [15:0] STREAM = 16'he980;
  logic [5:0] slot_reg;
  logic [5:0] slot_next;
  logic       zc_reg;
  logic       zc_next;
  logic       rx_reg;
  logic       rx_next;
  logic [3:0] idx_reg;
  logic [3:0] idx_next;
  always_comb
  begin
    slot_next = (slot_reg == 6'h27) ? 6'h00 : slot_reg + 6'h01;
    zc_next   = (slot_reg == 6'h00) ? ~zc_reg : zc_reg;
    // Pin moves mid half-cycle, far from the bit instant; the pattern holds no 11 pair
    rx_next   = (slot_reg == 6'h1e) ? STREAM[4'hf - idx_reg] : rx_reg;
    idx_next  = (slot_reg == 6'h1e) ? idx_reg + 4'h1 : idx_reg;
  end
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      slot_reg <= 6'h00;
      zc_reg   <= 1'b0;
      rx_reg   <= 1'b0;
      idx_reg  <= 4'h0;
    end
    else
    begin
      slot_reg <= slot_next;
      zc_reg   <= zc_next;
      rx_reg   <= rx_next;
      idx_reg  <= idx_next;
    end
  end
  // Second pulse has no crossing before it, so it must not step the line
  assign compare_match = (slot_reg == 6'h0a) || (slot_reg == 6'h19);
  assign zero_cross    = zc_reg;
  assign rx_pin        = rx_reg;
  assign slot          = slot_reg;
endmodule : plcb_mains_model

/* File: tb/testbench.sv */
// Self-checking bench for the powerline bit-stream channel
`timescale 1ns/1ps
module testbench;
  logic            clock;
  logic            reset;
  logic            open_req;
  logic [7:0]      open_channel;
  logic [2:0]      open_tx_mask;
  logic [2:0]      open_rx_mask;
  logic            close_req;
  logic [7:0]      close_channel;
  logic [2:0]      zsel;
  logic [7:0]      irq_lines;
  logic            rtc_present;
  logic            cmp_present;
  logic [5:0]      tx_valid;
  logic [5:0][7:0] tx_data;
  logic [5:0]      tx_ready;
  logic [5:0]      rx_valid;
  logic [5:0][7:0] rx_data;
  logic [5:0]      rx_ready;
  logic [5:0]      rx_line_in;
  logic [4:0]      rx_rand;
  logic [5:0]      tx_line_out;
  logic [5:0]      tx_line_oe;
  logic [1:0]      channel_active;
  logic            open_accepted;
  logic            zc_reserved;
  logic            zero_cross;
  logic            compare_match;
  logic            rx_pin;
  logic [5:0]      slot;
  logic [7:0]      txq[6][$];
  logic            eb[6][$];
  logic [7:0]      rbits[6];
  logic [1:0]      act;
  logic [5:0]      rx_on;
  logic [5:0]      rdone;
  int              rcnt[6];
  int              n_fail = 0;
  int              cmp_count = 0;
  int              cycles = 0;
  integer          seed;

  assign irq_lines  = zero_cross ? (8'h01 << zsel) : 8'h00;
  assign rx_line_in = {rx_rand, rx_pin};

  plcb_channel plcb_channel_i (.clock(clock), .reset(reset), .open_req(open_req),
    .open_channel(open_channel), .open_tx_mask(open_tx_mask), .open_rx_mask(open_rx_mask),
    .close_req(close_req), .close_channel(close_channel), .zero_cross_irq_sel(zsel),
    .irq_lines(irq_lines), .rtc_present(rtc_present), .second_compare_present(cmp_present),
    .second_compare_match(compare_match), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .rx_line_in(rx_line_in), .tx_line_out(tx_line_out), .tx_line_oe(tx_line_oe),
    .channel_active(channel_active), .open_accepted(open_accepted),
    .zero_cross_reserved(zc_reserved));
  plcb_mains_model plcb_mains_model_i (.clock(clock), .reset(reset), .zero_cross(zero_cross),
    .compare_match(compare_match), .rx_pin(rx_pin), .slot(slot));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Queue heads follow the lane's own take strobe
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    for (int l = 0; l < 6; l++)
    begin
      if (tx_valid[l] === 1'b1 && tx_ready[l] === 1'b1)
        void'(txq[l].pop_front());
      tx_valid[l] <= (txq[l].size() != 0);
      tx_data[l]  <= (txq[l].size() != 0) ? txq[l][0] : 8'h00;
    end
    if (cycles == 4000)
    begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic wait_slot(input logic [5:0] s);
    @(negedge clock);
    while (slot !== s)
      @(negedge clock);
  endtask : wait_slot

  task automatic open_try(input logic [7:0] ch, input logic [2:0] txm, input logic [2:0] rxm,
                          input logic ok);
    @(posedge clock);
    open_req     <= 1'b1;
    open_channel <= ch;
    open_tx_mask <= txm;
    open_rx_mask <= rxm;
    @(posedge clock);
    open_req <= 1'b0;
    @(negedge clock);
    if (ok)
      act[ch[1]] = 1'b1;
    chk_bit(open_accepted, ok);
    chk_byte({6'h00, channel_active}, {6'h00, act});
    chk_bit(zc_reserved, |act);
  endtask : open_try

  task automatic close_ch(input logic [7:0] ch);
    @(posedge clock);
    close_req     <= 1'b1;
    close_channel <= ch;
    @(posedge clock);
    close_req <= 1'b0;
    @(negedge clock);
    if (ch == 8'h01 || ch == 8'h02)
      act[ch[1]] = 1'b0;
    chk_byte({6'h00, channel_active}, {6'h00, act});
    chk_bit(zc_reserved, |act);
  endtask : close_ch

  // Host builds every bit of the stream; lane must pass the byte as is
  task automatic send(input int l, input logic [7:0] d, input logic en);
    txq[l].push_back(d);
    for (int i = 7; i >= 0; i--)
      if (en)
        eb[l].push_back(d[i]);
  endtask : send

  task automatic run_periods(input int n);
    logic b;
    repeat (n)
    begin
      wait_slot(6'h14);
      rdone = 6'h00;
      for (int l = 0; l < 6; l++)
      begin
        b = (eb[l].size() != 0);
        chk_bit(tx_line_oe[l], b);
        chk_bit(tx_line_out[l], b ? eb[l].pop_front() : 1'b0);
        if (rx_on[l])
        begin
          rbits[l] = {rbits[l][6:0], rx_line_in[l]};
          rcnt[l]++;
        end
        chk_bit(rx_valid[l], rcnt[l] == 8);
        if (rcnt[l] == 8)
        begin
          chk_byte(rx_data[l], rbits[l]);
          rcnt[l]  = 0;
          rdone[l] = 1'b1;
        end
      end
      chk_bit(zc_reserved, |act);
      chk_byte({2'h0, rx_valid & ~rx_on}, 8'h00);
      @(posedge clock);
      rx_ready <= rdone;
      @(posedge clock);
      rx_ready <= 6'h00;
      @(posedge clock);
      rx_rand <= 5'($random(seed));
    end
  endtask : run_periods

  task automatic final_report();
    $display("Summary: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial
  begin
    seed          = 32'hf9e3;
    reset         = 1'b1;
    open_req      = 1'b0;
    open_channel  = 8'h00;
    open_tx_mask  = 3'h0;
    open_rx_mask  = 3'h0;
    close_req     = 1'b0;
    close_channel = 8'h00;
    zsel          = plcb_pkg::IRQ_SEL_RESET;
    rtc_present   = 1'b1;
    cmp_present   = 1'b1;
    tx_valid      = '0;
    tx_data       = '0;
    rx_ready      = '0;
    rx_rand       = '0;
    act           = 2'h0;
    rx_on         = 6'h00;
    rdone         = 6'h00;
    for (int l = 0; l < 6; l++)
    begin
      rbits[l] = 8'h00;
      rcnt[l]  = 0;
    end
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    open_try(8'h00, 3'h1, 3'h1, 1'b0);
    open_try(8'h03, 3'h1, 3'h1, 1'b0);
    open_try(8'hff, 3'h7, 3'h7, 1'b0);
    open_try(8'h01, 3'h0, 3'h0, 1'b0);
    @(posedge clock);
    rtc_present <= 1'b0;
    open_try(8'h01, 3'h1, 3'h0, 1'b0);
    @(posedge clock);
    rtc_present <= 1'b1;
    cmp_present <= 1'b0;
    open_try(8'h02, 3'h0, 3'h1, 1'b0);
    @(posedge clock);
    cmp_present <= 1'b1;
    $display("Test refused opens done");
    wait_slot(6'h19);
    open_try(8'h01, 3'h1, 3'h1, 1'b1);
    open_try(8'h02, 3'h6, 3'h0, 1'b1);
    open_try(8'h01, 3'h2, 3'h0, 1'b0);
    rx_on[0] = 1'b1;
    send(0, 8'he9, 1'b1);
    send(0, 8'h80, 1'b1);
    send(0, 8'hff, 1'b1);
    send(3, 8'ha5, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      send(4, 8'($random(seed)), 1'b1);
      send(5, 8'($random(seed)), 1'b1);
    end
    run_periods(28);
    $display("Test stream on both channels done");
    wait_slot(6'h19);
    close_ch(8'h00);
    close_ch(8'h01);
    close_ch(8'h02);
    rx_on[0] = 1'b0;
    rcnt[0]  = 0;
    @(posedge clock);
    zsel <= 3'h5;
    open_try(8'h01, 3'h1, 3'h0, 1'b1);
    send(0, 8'h3c, 1'b1);
    // Receive-only on the third phase of channel 2
    open_try(8'h02, 3'h0, 3'h4, 1'b1);
    rx_on[5] = 1'b1;
    run_periods(10);
    $display("Test alternate crossing line done");
    final_report();
  end
endmodule : testbench
